// *** shared/asp_pkg.sv ***
package asp_pkg;

    // ------------------------------------------------------------
    // Result word
    // ------------------------------------------------------------
    localparam int RESULT_BITS = 16;
    localparam int BIT_CNT_W = 5;
    localparam logic [4:0] BIT_CNT_RESET = 5'h00;
    localparam logic [4:0] BIT_CNT_LAST = 5'h0f;
    localparam logic [4:0] BIT_CNT_DONE = 5'h10;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_SYS_NS = 25;
    localparam int SLAVE_SCLK_MAX_MHZ = 40;
    localparam int MASTER_SCLK_PERIOD_NS = 100;
    localparam int MASTER_HALF_RAW = (MASTER_SCLK_PERIOD_NS / 2) / CLK_SYS_NS;
    localparam int MASTER_HALF_CYC = (MASTER_HALF_RAW < 1) ? 1 : MASTER_HALF_RAW;
    localparam int DIV_W = 8;
    localparam logic [7:0] DIV_RESET = 8'h00;

    // ------------------------------------------------------------
    // Configuration pins, carried together
    // ------------------------------------------------------------
    typedef struct packed {
        logic port_select;
        logic clock_source_select;
        logic read_timing;
        logic clock_invert;
        logic frame_invert;
    } asp_cfg_t;

    localparam asp_cfg_t CFG_RESET = '0;

endpackage

// *** hdl/asp_sync3.sv ***
`timescale 1ns/1ps

module asp_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ------------------------------------------------------------
    // Three stages; a change is taken once stages two and three agree
    // ------------------------------------------------------------
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    out_q[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    out_q[i] <= s3_q[i];
                end
            end
        end
    endgenerate

    assign q = out_q;

endmodule

// *** hdl/asp_serial_port.sv ***
`timescale 1ns/1ps

// What this block does
// - Serial port active while port select high
// - Sixteen result bits, MSB first
// - Bits stable across the rising clock edge, change on the falling
// - Source select low: master drives clock, strobe
// - Master clock and strobe polarity selectable
// - Master reads after or during conversion
// - Master read-after: busy held until sixteenth bit
// - Master read-during: edges avoid conversion decision instants
// - Source select high: external shift clock
// - Slave shifts only with select, read low
// - Slave accepts continuous or gated clocks
// - Slave read-after once busy falls
// - Slave read-after offers chain input
// - Chain bits captured on opposite edge
// - Slave read-during: unread previous word pulses read error
// - Read may spill into next conversion
// - Select or read high floats outputs

module asp_serial_port #(
    parameter int BITS = asp_pkg::RESULT_BITS,
    parameter int HALF_CYC = asp_pkg::MASTER_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sclk_link,
    input wire logic port_select,
    input wire logic clock_source_select,
    input wire logic read_timing_or_chain_in,
    input wire logic clock_invert_select,
    input wire logic frame_invert_select,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic conv_busy,
    input wire logic conv_decide,
    input wire logic [BITS-1:0] result_data,
    output logic busy_out,
    output logic incomplete_read_flag,
    output logic read_pending,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic sclk_out,
    output logic sclk_oe,
    output logic frame_valid_out,
    output logic frame_valid_oe
);

    typedef enum logic {
        M_IDLE,
        M_RUN
    } asp_mstate_t;

    // ------------------------------------------------------------
    // Pin synchronisation into the system clock
    // ------------------------------------------------------------
    asp_pkg::asp_cfg_t cfg_raw;
    asp_pkg::asp_cfg_t cfg;

    assign cfg_raw = '{
        port_select: port_select,
        clock_source_select: clock_source_select,
        read_timing: read_timing_or_chain_in,
        clock_invert: clock_invert_select,
        frame_invert: frame_invert_select
    };

    asp_sync3 #(
        .WIDTH($bits(asp_pkg::asp_cfg_t))
    ) u_cfg_sync (
        .clk(clk_sys),
        .rst(sys_rst),
        .d(cfg_raw),
        .q(cfg)
    );

    wire master_mode = cfg.port_select & ~cfg.clock_source_select;
    wire slave_mode = cfg.port_select & cfg.clock_source_select;
    // High selects read-during-conversion
    wire rdc_mode = cfg.read_timing;

    // ------------------------------------------------------------
    // Conversion edges and result holding
    // ------------------------------------------------------------
    logic busy_prev_q;
    logic [BITS-1:0] word_q;

    wire busy_rise = conv_busy & ~busy_prev_q;
    wire busy_fall = ~conv_busy & busy_prev_q;

    // Word changes only at end of conversion; the link side reads it
    // as a quasi-static value between those moments.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            busy_prev_q <= 1'b0;
            word_q <= '0;
        end else begin
            busy_prev_q <= conv_busy;
            if (busy_fall) begin
                word_q <= result_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Master shifter, clocked from clk_sys by a divider
    // ------------------------------------------------------------
    asp_mstate_t m_state_q;
    asp_mstate_t m_state_d;
    logic [asp_pkg::DIV_W-1:0] m_div_q;
    logic [asp_pkg::DIV_W-1:0] m_div_d;
    logic [asp_pkg::BIT_CNT_W-1:0] m_bit_q;
    logic [asp_pkg::BIT_CNT_W-1:0] m_bit_d;
    logic [BITS-1:0] m_shift_q;
    logic [BITS-1:0] m_shift_d;
    logic m_sclk_q;
    logic m_sclk_d;
    logic m_rac_q;
    logic m_rac_d;

    localparam logic [asp_pkg::DIV_W-1:0] DIV_LAST = asp_pkg::DIV_W'(HALF_CYC - 1);

    wire m_idle = (m_state_q == M_IDLE);
    wire m_run = (m_state_q == M_RUN);
    wire start_rdc = master_mode & rdc_mode & busy_rise & m_idle;
    wire start_rac = master_mode & ~rdc_mode & busy_fall & m_idle;
    // Read-during edges are held off while the converter decides a bit
    wire m_hold = conv_decide & ~m_rac_q;
    wire m_tick = m_run & ~m_hold & (m_div_q == DIV_LAST);
    wire m_last = (m_bit_q == asp_pkg::BIT_CNT_LAST);

    always_comb begin
        m_state_d = m_state_q;
        m_div_d = m_div_q;
        m_bit_d = m_bit_q;
        m_shift_d = m_shift_q;
        m_sclk_d = m_sclk_q;
        m_rac_d = m_rac_q;
        case (m_state_q)
            M_IDLE: begin
                m_div_d = asp_pkg::DIV_RESET;
                m_bit_d = asp_pkg::BIT_CNT_RESET;
                m_sclk_d = 1'b0;
                if (start_rac) begin
                    m_shift_d = result_data;
                    m_rac_d = 1'b1;
                    m_state_d = M_RUN;
                end else if (start_rdc) begin
                    // Previous result goes out during this conversion
                    m_shift_d = word_q;
                    m_rac_d = 1'b0;
                    m_state_d = M_RUN;
                end
            end
            M_RUN: begin
                if (m_hold) begin
                    m_div_d = m_div_q;
                end else if (m_tick) begin
                    m_div_d = asp_pkg::DIV_RESET;
                end else begin
                    m_div_d = m_div_q + 1'b1;
                end
                if (m_tick) begin
                    // Rising half: host samples; falling half: next bit
                    m_sclk_d = ~m_sclk_q;
                    if (m_sclk_q) begin
                        m_shift_d = {m_shift_q[BITS-2:0], 1'b0};
                        m_bit_d = m_bit_q + 1'b1;
                        if (m_last) begin
                            m_state_d = M_IDLE;
                        end
                    end
                end
                if (!master_mode) begin
                    m_state_d = M_IDLE;
                end
            end
            default: begin
                m_state_d = M_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            m_state_q <= M_IDLE;
            m_div_q <= asp_pkg::DIV_RESET;
            m_bit_q <= asp_pkg::BIT_CNT_RESET;
            m_shift_q <= asp_pkg::WORD_RESET;
            m_sclk_q <= 1'b0;
            m_rac_q <= 1'b0;
        end else begin
            m_state_q <= m_state_d;
            m_div_q <= m_div_d;
            m_bit_q <= m_bit_d;
            m_shift_q <= m_shift_d;
            m_sclk_q <= m_sclk_d;
            m_rac_q <= m_rac_d;
        end
    end

    // Read-after busy stretched until the last master bit has left
    assign busy_out = conv_busy | (m_run & m_rac_q);

    // ------------------------------------------------------------
    // Slave shifter on the host's clock
    // ------------------------------------------------------------
    // The frame's own pins end a transfer, so a stopped clock never
    // leaves the counter stranded mid-word.
    wire link_rst = sys_rst | cs_n | rd_n;

    logic l_seen_rise_q;
    logic [BITS-1:0] l_chain_q;
    logic [asp_pkg::BIT_CNT_W-1:0] l_cnt_q;
    logic l_done_q;
    logic l_up_q;

    // Idle-high clocks give a lone falling edge first; it is skipped
    always_ff @(posedge sclk_link or posedge link_rst) begin
        if (link_rst) begin
            l_seen_rise_q <= 1'b0;
            l_chain_q <= '0;
            l_done_q <= 1'b0;
        end else begin
            l_seen_rise_q <= 1'b1;
            l_chain_q <= {l_chain_q[BITS-2:0], read_timing_or_chain_in};
            // Sixteenth rise ends the word whether the clock idles high or low
            if (l_cnt_q == asp_pkg::BIT_CNT_LAST) begin
                l_done_q <= 1'b1;
            end
        end
    end

    always_ff @(negedge sclk_link or posedge link_rst) begin
        if (link_rst) begin
            l_cnt_q <= asp_pkg::BIT_CNT_RESET;
            l_up_q <= 1'b0;
        end else if (l_seen_rise_q) begin
            if (l_cnt_q != asp_pkg::BIT_CNT_DONE) begin
                l_cnt_q <= l_cnt_q + 1'b1;
            end
            // Chain bit moves on the shifting edge, never on the sampling one
            l_up_q <= l_chain_q[BITS-1];
        end
    end

    wire l_in_word = (l_cnt_q < asp_pkg::BIT_CNT_DONE);
    wire [3:0] l_index = 4'(BITS - 1) - l_cnt_q[3:0];
    // After the own word, the upstream word follows bit for bit
    wire l_bit = l_in_word ? word_q[l_index] : l_up_q;

    // ------------------------------------------------------------
    // Read completion back in the system clock
    // ------------------------------------------------------------
    logic done_sync;
    logic done_prev_q;
    logic unread_q;
    logic unread_d;
    logic err_q;

    asp_sync3 #(
        .WIDTH(1)
    ) u_done_sync (
        .clk(clk_sys),
        .rst(sys_rst),
        .d(l_done_q),
        .q(done_sync)
    );

    wire done_rise = done_sync & ~done_prev_q;
    // New result wins over a completion seen in the same cycle
    assign unread_d = busy_fall ? 1'b1 : (done_rise ? 1'b0 : unread_q);
    wire err_hit = slave_mode & rdc_mode & busy_fall & unread_q & ~done_rise;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            done_prev_q <= 1'b0;
            unread_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            done_prev_q <= done_sync;
            unread_q <= unread_d;
            err_q <= err_hit;
        end
    end

    assign incomplete_read_flag = err_q;
    assign read_pending = unread_q;

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Enables follow the raw pins so the bus floats immediately
    wire port_open = port_select & ~(cs_n | rd_n);
    wire raw_master = ~clock_source_select;

    assign serial_data_out = master_mode ? m_shift_q[BITS-1] : l_bit;
    assign serial_data_oe = port_open;
    assign sclk_out = m_sclk_q ^ cfg.clock_invert;
    assign sclk_oe = port_open & raw_master;
    assign frame_valid_out = m_run ^ cfg.frame_invert;
    assign frame_valid_oe = port_open & raw_master;

endmodule

// *** tb/asp_chk.sv ***
`timescale 1ns/1ps

module asp_chk (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic port_select,
    input wire logic clock_source_select,
    input wire logic read_timing_or_chain_in,
    input wire logic clock_invert_select,
    input wire logic frame_invert_select,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic conv_busy,
    input wire logic conv_decide,
    input wire logic busy_out,
    input wire logic incomplete_read_flag,
    input wire logic serial_data_oe,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic frame_valid_out,
    input wire logic frame_valid_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ----------------------------
    // Rising shift edges per frame
    // ----------------------------
    logic sclk_q;
    logic [4:0] rise_q;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
            rise_q <= 5'h00;
        end else begin
            sclk_q <= sclk_out;
            rise_q <= frame_valid_out ? rise_q + {4'h0, sclk_out & ~sclk_q} : 5'h00;
        end
    end
    sequence s_open;
        $rose(frame_valid_out) && !frame_invert_select && !clock_invert_select;
    endsequence
    sequence s_first_bit;
        !sclk_out ##[1:8] sclk_out;
    endsequence
    AST_OE: assert property (serial_data_oe == (port_select && !cs_n && !rd_n))
        else $error("data enable wrong");
    AST_MASTER_OE: assert property (sclk_oe == (serial_data_oe && !clock_source_select))
        else $error("clock enable wrong");
    AST_FRAME_OE: assert property (frame_valid_oe == sclk_oe)
        else $error("strobe enable wrong");
    AST_FIRST: assert property (s_open |-> s_first_bit)
        else $error("first shift edge missing");
    // Invert pins pass a synchroniser, so their recent history guards the checks
    AST_SPAN: assert property ($fell(frame_valid_out) && !$past(frame_invert_select, 8)
        && !$past(clock_invert_select, 8) |-> rise_q == 5'h10)
        else $error("frame not sixteen edges");
    AST_HOLD: assert property (frame_valid_out && !frame_invert_select
        && !$past(frame_invert_select, 8) && !clock_source_select
        && !read_timing_or_chain_in |-> busy_out)
        else $error("busy dropped in transfer");
    AST_DECIDE: assert property (conv_decide && !clock_source_select
        && read_timing_or_chain_in |=> $stable(sclk_out))
        else $error("clock moved in decision");
    AST_PULSE: assert property (incomplete_read_flag |=> !incomplete_read_flag)
        else $error("error flag too long");
    AST_CAUSE: assert property (incomplete_read_flag |-> $past(conv_busy, 2)
        && !$past(conv_busy) && clock_source_select && read_timing_or_chain_in)
        else $error("error flag without cause");
endmodule

bind asp_serial_port asp_chk asp_chk_inst (
    .clk_sys, .sys_rst, .port_select, .clock_source_select, .read_timing_or_chain_in,
    .clock_invert_select, .frame_invert_select, .cs_n, .rd_n, .conv_busy, .conv_decide,
    .busy_out, .incomplete_read_flag, .serial_data_oe, .sclk_out, .sclk_oe, .frame_valid_out,
    .frame_valid_oe
);

// *** tb/asp_host.sv ***
`timescale 1ns/1ps

module asp_host (
    input wire logic sclk_out,
    input wire logic frame_valid_out,
    input wire logic serial_data_out,
    input wire logic inv,
    output logic sclk_link,
    output logic cs_n,
    output logic rd_n,
    output logic [15:0] rx_word,
    output logic rx_tgl
);
    logic [15:0] sh;
    int n;
    wire logic fa = frame_valid_out ^ inv;
    wire logic ca = sclk_out ^ inv;
    initial begin
        {sclk_link, cs_n, rd_n, rx_tgl, n, sh, rx_word} = '0;
    end
    // Master frames: sample on the true rising edge only
    always @(posedge ca) begin
        if (fa) begin
            sh = {sh[14:0], serial_data_out};
            n = n + 1;
            if (n == 16) begin
                rx_word = sh;
                rx_tgl = !rx_tgl;
            end
        end
    end
    always @(negedge fa) n = 0;
    task automatic sel(input logic v);
        cs_n = v;
        rd_n = v;
    endtask
    // Gated clock, still outside the frame; 48 ns period
    task automatic rd(input logic hi, input int nb);
        logic [15:0] w;
        sclk_link = hi;
        #7 sel(1'b0);
        #30;
        repeat (nb) begin
            if (hi) begin
                sclk_link = 1'b0;
                #24;
            end
            w = {w[14:0], serial_data_out};
            sclk_link = 1'b1;
            #24;
            if (!hi) begin
                sclk_link = 1'b0;
                #24;
            end
        end
        #30 sel(1'b1);
        rx_word = w;
        rx_tgl = !rx_tgl;
    endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
    logic clk_sys, sys_rst, sclk_link, port_select, css, rt, inv, cs_n, rd_n;
    logic conv_busy, conv_decide, busy_out, flag, pend, sdo, sdo_oe, sclk_out, sclk_oe;
    logic fv, fv_oe, rx_tgl;
    logic [15:0] result_data, rx_word, last;
    logic [15:0] exp_q[$];
    int error_cnt, n_tests, flags, seed;

    asp_serial_port #(.HALF_CYC(1)) asp_serial_port_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .sclk_link(sclk_link),
        .port_select(port_select), .clock_source_select(css), .read_timing_or_chain_in(rt),
        .clock_invert_select(inv), .frame_invert_select(inv), .cs_n(cs_n), .rd_n(rd_n),
        .conv_busy(conv_busy), .conv_decide(conv_decide), .result_data(result_data),
        .busy_out(busy_out), .incomplete_read_flag(flag), .read_pending(pend),
        .serial_data_out(sdo), .serial_data_oe(sdo_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .frame_valid_out(fv), .frame_valid_oe(fv_oe)
    );
    asp_host asp_host_inst (
        .sclk_out(sclk_out), .frame_valid_out(fv), .serial_data_out(sdo), .inv(inv),
        .sclk_link(sclk_link), .cs_n(cs_n), .rd_n(rd_n), .rx_word(rx_word), .rx_tgl(rx_tgl)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) if (flag === 1'b1) flags++;

    task automatic results();
        if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value serial word expected %h seen %h", e, g);
        end
    endtask
    task automatic cmp_cnt(input int e, input int g);
        n_tests++;
        if (g != e) begin
            error_cnt++;
            $display("wrong value error pulses expected %0d seen %0d", e, g);
        end
    endtask
    task automatic cmp_bit(input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value read pending expected %b seen %b", e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic conv(input int len, input logic dec);
        logic [31:0] r;
        conv_busy = 1'b1;
        repeat (len) begin
            r = $random(seed);
            conv_decide = dec & (r[1:0] == 2'h0);
            tick(1);
        end
        r = $random(seed);
        conv_decide = 1'b0;
        result_data = r[15:0];
        last = r[15:0];
        conv_busy = 1'b0;
        tick(1);
    endtask

    // Every delivered word is matched against the oldest note
    initial begin
        #1;
        forever begin
            @(rx_tgl);
            cmp_word(exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx, rx_word);
        end
    end
    initial begin
        #500000;
        error_cnt++;
        results();
    end
    initial begin
        seed = 32'hea93;
        {error_cnt, n_tests, flags} = '0;
        {sys_rst, port_select, css, rt, inv, conv_busy, conv_decide} = 7'h40;
        result_data = 16'h0000;
        last = 16'h0000;
        tick(16);
        sys_rst = 1'b0;
        asp_host_inst.sel(1'b0);
        tick(8);
        port_select = 1'b1;
        for (int i = 0; i < 2; i++) begin
            inv = i[0];
            tick(8);
            conv(20, 1'b0);
            exp_q.push_back(last);
            for (int k = 0; k < 200 && busy_out !== 1'b0; k++) tick(1);
            tick(4);
        end
        inv = 1'b0;
        rt = 1'b1;
        tick(8);
        repeat (2) begin
            exp_q.push_back(last);
            conv(100, 1'b1);
        end
        tick(10);
        asp_host_inst.sel(1'b1);
        css = 1'b1;
        rt = 1'b0;
        tick(8);
        for (int i = 1; i >= 0; i--) begin
            conv(20, 1'b0);
            exp_q.push_back(last);
            cmp_bit(1'b1, pend);
            asp_host_inst.rd(i[0], 16);
            tick(8);
            cmp_bit(1'b0, pend);
        end
        conv(20, 1'b0);
        rt = 1'b1;
        exp_q.push_back(16'hffff);
        asp_host_inst.rd(1'b0, 32);
        tick(8);
        rt = 1'b1;
        tick(8);
        flags = 0;
        conv(40, 1'b0);
        conv(40, 1'b0);
        tick(4);
        cmp_cnt(1, flags);
        exp_q.push_back(last);
        fork
            conv(100, 1'b0);
            begin
                tick(5);
                asp_host_inst.rd(1'b0, 16);
            end
        join
        tick(10);
        cmp_cnt(1, flags);
        results();
    end
endmodule
